// *** rtcc_regs.vh ***
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// register byte offsets
`define RTCC_OFF_CTRL1      8'h00
`define RTCC_OFF_CTRL2      8'h04
`define RTCC_OFF_CSR        8'h08
`define RTCC_OFF_FLAG       8'h0C
`define RTCC_OFF_SEC        8'h10
`define RTCC_OFF_MIN        8'h14
`define RTCC_OFF_HOUR       8'h18
`define RTCC_OFF_WEEK       8'h1C

// control one fields
`define RTCC_C1_RUN         7
`define RTCC_C1_FMT24       6
`define RTCC_C1_PM          5
`define RTCC_C1_SRST        4

// enable fields
`define RTCC_EN_OVF         5
`define RTCC_EN_WEEK        4
`define RTCC_EN_DAY         3
`define RTCC_EN_HOUR        2
`define RTCC_EN_MIN         1
`define RTCC_EN_SEC         0

// source and output select fields
`define RTCC_CS_OUT_HI      6
`define RTCC_CS_OUT_LO      5
`define RTCC_CS_SRC_HI      3
`define RTCC_CS_SRC_LO      0
`define RTCC_SRC_32K        4'h8

// flag field
`define RTCC_FLAG_BIT       0

// reset values
`define RTCC_RST_CTRL1      8'h00
`define RTCC_RST_CTRL2      8'h00
`define RTCC_RST_CSR        8'h08

// counting limits
`define RTCC_SUB_MAX        15'h7FFF
`define RTCC_SEC_MAX        6'h3B
`define RTCC_MIN_MAX        6'h3B
`define RTCC_HR12_MAX       5'h0B
`define RTCC_HR24_MAX       5'h17
`define RTCC_WEEK_MAX       3'h6
`define RTCC_FR_MAX         8'hFF

`endif

// *** rtcc_fdiv.v ***
`include "rtcc_regs.vh"

module rtcc_fdiv (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [2:0] src_sel,
    input  wire [1:0] out_sel,
    input  wire       out_allow,
    output wire       cnt_tick,
    output wire       clk_out
);

    reg  [9:0] pre_q;
    reg        tick_q;
    reg        clk_q;
    reg        out_bit;
    wire [9:0] mask;

    // mask of low ones for a division of 2 to the (3 + n)
    function [9:0] low_ones;
        input [2:0] n;
        integer     i;
        begin
            low_ones = 10'h000;
            for (i = 0; i < 10; i = i + 1) begin
                if (i < n + 3)
                    low_ones[i] = 1'b1;
            end
        end
    endfunction

    assign mask = low_ones(src_sel);

    // pick the prescaler bit for the output ratio
    always @* begin
        case (out_sel)
            2'b00:   out_bit = pre_q[1];   // phi/4
            2'b01:   out_bit = pre_q[2];   // phi/8
            2'b10:   out_bit = pre_q[3];   // phi/16
            2'b11:   out_bit = pre_q[4];   // phi/32
            default: out_bit = 1'b0;
        endcase
    end

    // free prescaler, count tick and gated clock output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q  <= 10'h000;
            tick_q <= 1'b0;
            clk_q  <= 1'b0;
        end else begin
            pre_q  <= pre_q + 10'h001;
            tick_q <= ((pre_q & mask) == mask);
            clk_q  <= out_allow & out_bit;
        end
    end

    assign cnt_tick = tick_q;
    assign clk_out  = clk_q;

endmodule

// *** rtcc_top.v ***
`include "rtcc_regs.vh"

module rtcc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        tick_32k,
    input  wire        cpu_active_or_sleep,
    input  wire        clk_out_pin_en,
    output wire        clock_output_pin,
    output wire        clock_irq_request_flag,
    output wire        free_run_mode
);

    // register state
    reg  [7:0]  ctrl1_q;
    reg  [7:0]  ctrl1_d;
    reg  [7:0]  ctrl2_q;
    reg  [7:0]  ctrl2_d;
    reg  [7:0]  csr_q;
    reg  [7:0]  csr_d;
    reg         flag_q;
    reg         flag_d;

    // counting state
    reg  [14:0] sub_q;
    reg  [14:0] sub_d;
    reg  [5:0]  sec_q;
    reg  [5:0]  sec_d;
    reg  [5:0]  min_q;
    reg  [5:0]  min_d;
    reg  [4:0]  hour_q;
    reg  [4:0]  hour_d;
    reg  [2:0]  week_q;
    reg  [2:0]  week_d;
    reg  [7:0]  fr_q;
    reg  [7:0]  fr_d;

    // bus answer state
    reg  [31:0] prdata_q;
    reg  [31:0] prdata_d;
    reg         err_q;
    reg         err_d;

    // decoded strobes and events
    wire        setup_ph;
    wire        wr_en;
    wire        hit_c1;
    wire        hit_c2;
    wire        hit_cs;
    wire        hit_fl;
    wire        hit_sec;
    wire        hit_min;
    wire        hit_hr;
    wire        hit_wk;
    wire        mapped;
    wire        run;
    wire        fmt24;
    wire        pm;
    wire        srst;
    wire        srst_hold;
    wire        rtc_mode;
    wire        div_tick;
    wire [4:0]  hr_max;
    wire        sec_tick;
    wire        sec_wrap;
    wire        min_wrap;
    wire        hr_wrap;
    wire        day_tick;
    wire        wk_wrap;
    wire        fr_tick;
    wire        fr_ovf;
    wire [4:0]  events;
    wire [4:0]  ev_gated;
    wire        flag_set;
    wire        flag_clr;
    wire [7:0]  sec_rd;

    // address match against a register offset
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // bus phases; the slave never inserts wait states
    assign setup_ph = psel & ~penable;
    assign wr_en    = psel & penable & pwrite;
    assign pready   = 1'b1;

    // register decode, shared by reads and writes
    assign hit_c1  = hit(paddr, `RTCC_OFF_CTRL1);
    assign hit_c2  = hit(paddr, `RTCC_OFF_CTRL2);
    assign hit_cs  = hit(paddr, `RTCC_OFF_CSR);
    assign hit_fl  = hit(paddr, `RTCC_OFF_FLAG);
    assign hit_sec = hit(paddr, `RTCC_OFF_SEC);
    assign hit_min = hit(paddr, `RTCC_OFF_MIN);
    assign hit_hr  = hit(paddr, `RTCC_OFF_HOUR);
    assign hit_wk  = hit(paddr, `RTCC_OFF_WEEK);
    assign mapped  = hit_c1 | hit_c2 | hit_cs | hit_fl |
                     hit_sec | hit_min | hit_hr | hit_wk;

    // control fields
    assign run   = ctrl1_q[`RTCC_C1_RUN];
    assign fmt24 = ctrl1_q[`RTCC_C1_FMT24];
    assign pm    = ctrl1_q[`RTCC_C1_PM];
    assign srst  = ctrl1_q[`RTCC_C1_SRST];

    // anything but the 32.768 kHz code turns the block into a counter
    assign rtc_mode = (csr_q[`RTCC_CS_SRC_HI:`RTCC_CS_SRC_LO] ==
                       `RTCC_SRC_32K);
    assign free_run_mode = ~rtc_mode;

    // hour limit by format
    assign hr_max = fmt24 ? `RTCC_HR24_MAX : `RTCC_HR12_MAX;

    // soft reset also takes hold in the cycle of the write that sets it,
    // so no other field shows a stale value or steps once more
    assign srst_hold = srst |
                       (wr_en & hit_c1 & pwdata[`RTCC_C1_SRST]);

    // time chain carries, frozen while stopped or held in soft reset
    assign sec_tick = rtc_mode & run & ~srst_hold & tick_32k &
                      (sub_q == `RTCC_SUB_MAX);
    assign sec_wrap = sec_tick & (sec_q == `RTCC_SEC_MAX);
    assign min_wrap = sec_wrap & (min_q == `RTCC_MIN_MAX);
    assign hr_wrap  = min_wrap & (hour_q == hr_max);
    // in 12-hour format only the wrap with afternoon set is midnight
    assign day_tick = hr_wrap & (fmt24 | pm);
    assign wk_wrap  = day_tick & (week_q == `RTCC_WEEK_MAX);

    // free running counter steps
    assign fr_tick = ~rtc_mode & run & ~srst_hold & div_tick;
    assign fr_ovf  = fr_tick & (fr_q == `RTCC_FR_MAX);

    // periodic events in enable bit order
    assign events = {wk_wrap, day_tick, min_wrap, sec_wrap, sec_tick};

    // each periodic event gated by its own enable
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gate_ev
            assign ev_gated[g] = events[g] & ctrl2_q[g];
        end
    endgenerate

    // request flag: any enabled event, set beats a software clear
    assign flag_set = (|ev_gated) |
                      (fr_ovf & ctrl2_q[`RTCC_EN_OVF]);
    assign flag_clr = wr_en & hit_fl & ~pwdata[`RTCC_FLAG_BIT];

    // seconds register shows the counter in free running mode
    assign sec_rd = rtc_mode ? {2'b00, sec_q} : fr_q;

    // control register next state
    // reserved bits are never stored, so they always read back as 0
    always @* begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        csr_d   = csr_q;
        if (wr_en && hit_c1) begin
            ctrl1_d = {pwdata[7:4], 4'h0};
        end
        if (wr_en && hit_c2) begin
            ctrl2_d = {2'b00, pwdata[5:0]};
        end
        if (wr_en && hit_cs) begin
            csr_d = {1'b0, pwdata[6:5], 1'b0, pwdata[3:0]};
        end
        // hardware afternoon toggle at each 12-hour wrap
        if (hr_wrap && !fmt24) begin
            ctrl1_d[`RTCC_C1_PM] = ~pm;
        end
        // soft reset holds everything but itself, the source and output select and the request flag
        if (srst_hold) begin
            ctrl1_d = {3'b000, ctrl1_d[`RTCC_C1_SRST], 4'h0};
            ctrl2_d = `RTCC_RST_CTRL2;
        end
    end

    // flag next state
    // the set is applied last so an event is never lost to a clear
    always @* begin
        flag_d = flag_q;
        if (flag_clr) begin
            flag_d = 1'b0;
        end
        if (flag_set) begin
            flag_d = 1'b1;
        end
    end

    // time counters next state; a bus write overrides a step
    always @* begin
        sub_d  = sub_q;
        sec_d  = sec_q;
        min_d  = min_q;
        hour_d = hour_q;
        week_d = week_q;
        if (rtc_mode && run && !srst_hold && tick_32k) begin
            sub_d = sub_q + 15'h0001;
        end
        if (sec_tick) begin
            sec_d = sec_wrap ? 6'h00 : sec_q + 6'h01;
        end
        if (sec_wrap) begin
            min_d = min_wrap ? 6'h00 : min_q + 6'h01;
        end
        if (min_wrap) begin
            hour_d = hr_wrap ? 5'h00 : hour_q + 5'h01;
        end
        if (day_tick) begin
            week_d = wk_wrap ? 3'h0 : week_q + 3'h1;
        end
        if (wr_en && hit_sec && rtc_mode) begin
            sec_d = pwdata[5:0];
        end
        if (wr_en && hit_min) begin
            min_d = pwdata[5:0];
        end
        if (wr_en && hit_hr) begin
            hour_d = pwdata[4:0];
        end
        if (wr_en && hit_wk) begin
            week_d = pwdata[2:0];
        end
        if (srst_hold) begin
            sub_d  = 15'h0000;
            sec_d  = 6'h00;
            min_d  = 6'h00;
            hour_d = 5'h00;
            week_d = 3'h0;
        end
    end

    // free running counter next state
    always @* begin
        fr_d = fr_q;
        if (fr_tick) begin
            fr_d = fr_q + 8'h01;
        end
        if (wr_en && hit_sec && !rtc_mode) begin
            fr_d = pwdata[7:0];
        end
        if (srst_hold) begin
            fr_d = 8'h00;
        end
    end

    // read data captured in the setup phase, shown in the access phase
    // the bus never waits, so the word must be ready by the access phase
    always @* begin
        prdata_d = prdata_q;
        err_d    = 1'b0;
        if (setup_ph) begin
            err_d = ~mapped;
            case (1'b1)
                hit_c1:  prdata_d = {24'h000000, ctrl1_q};
                hit_c2:  prdata_d = {24'h000000, ctrl2_q};
                hit_cs:  prdata_d = {24'h000000, csr_q};
                hit_fl:  prdata_d = {31'h0, flag_q};
                hit_sec: prdata_d = {24'h000000, sec_rd};
                hit_min: prdata_d = {26'h0, min_q};
                hit_hr:  prdata_d = {27'h0, hour_q};
                hit_wk:  prdata_d = {29'h0, week_q};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    // register file flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= `RTCC_RST_CTRL1;
            ctrl2_q <= `RTCC_RST_CTRL2;
            csr_q   <= `RTCC_RST_CSR;
            flag_q  <= 1'b0;
        end else begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            csr_q   <= csr_d;
            flag_q  <= flag_d;
        end
    end

    // counter flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_q  <= 15'h0000;
            sec_q  <= 6'h00;
            min_q  <= 6'h00;
            hour_q <= 5'h00;
            week_q <= 3'h0;
            fr_q   <= 8'h00;
        end else begin
            sub_q  <= sub_d;
            sec_q  <= sec_d;
            min_q  <= min_d;
            hour_q <= hour_d;
            week_q <= week_d;
            fr_q   <= fr_d;
        end
    end

    // bus answer flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            err_q    <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            err_q    <= err_d;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = err_q & psel & penable;
    assign clock_irq_request_flag = flag_q;

    // system clock prescaler for count source and clock output
    // one shared prescaler keeps the count and output ratios in step
    rtcc_fdiv rtcc_fdiv_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_sel   (csr_q[2:0]),
        .out_sel   (csr_q[`RTCC_CS_OUT_HI:`RTCC_CS_OUT_LO]),
        .out_allow (clk_out_pin_en & cpu_active_or_sleep),
        .cnt_tick  (div_tick),
        .clk_out   (clock_output_pin)
    );

endmodule

// *** rtcc_properties.sv ***
module rtcc_props (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        cpu_active_or_sleep,
    input wire        clk_out_pin_en,
    input wire        clock_output_pin,
    input wire        clock_irq_request_flag,
    input wire        free_run_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus phase decode
    wire       rd = psel && penable && !pwrite;
    wire       wr = psel && penable && pwrite;
    wire [3:0] src = pwdata[3:0];
    reg        srst_q;
    // soft reset bit as software last wrote it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) srst_q <= 1'b0;
        else if (wr && paddr == 8'h00) srst_q <= pwdata[4];
    end
    a_res_ctrl_one: assert property (
        rd && paddr == 8'h00 |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
        else $error("ctrl one reserved bits set");
    a_res_enables: assert property (
        rd && paddr == 8'h04 |-> prdata[31:6] == 26'h0)
        else $error("enable reserved bits set");
    a_res_source: assert property (
        rd && paddr == 8'h08 |-> !prdata[7] && !prdata[4])
        else $error("source reserved bits set");
    a_srst_ctrl_one: assert property (
        rd && paddr == 8'h00 && srst_q |-> prdata[7:4] == 4'h1)
        else $error("ctrl one not held in soft reset");
    a_srst_enables: assert property (
        rd && paddr == 8'h04 && srst_q |-> prdata[5:0] == 6'h00)
        else $error("enables not held in soft reset");
    a_free_after_csr: assert property (
        wr && paddr == 8'h08 |=> free_run_mode == ($past(src) != 4'h8))
        else $error("free mode does not follow source");
    a_reset_src: assert property (
        !$past(presetn) |-> !free_run_mode)
        else $error("source not 32k after reset");
    a_clkout_gated: assert property (
        !(clk_out_pin_en && cpu_active_or_sleep) |=> !clock_output_pin)
        else $error("clock output while not allowed");
    a_flag_holds: assert property (
        clock_irq_request_flag && !(wr && paddr == 8'h0C)
        |=> clock_irq_request_flag)
        else $error("flag dropped without a clear");
endmodule

bind rtcc_top rtcc_props rtcc_props_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .cpu_active_or_sleep, .clk_out_pin_en, .clock_output_pin,
    .clock_irq_request_flag, .free_run_mode
);

// *** tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] C1 = 8'h00, C2 = 8'h04, CS = 8'h08, FL = 8'h0C;
    localparam logic [7:0] SE = 8'h10, MI = 8'h14, HR = 8'h18;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        tick_32k = 1'b0;
    logic        cpu_active_or_sleep = 1'b0;
    logic        clk_out_pin_en = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, clock_output_pin;
    wire         clock_irq_request_flag, free_run_mode;
    logic [31:0] rd;
    logic        serr;
    int          err_total = 0;
    int          n_tests = 0;

    // 250 MHz clock
    always #2 pclk = ~pclk;

    rtcc_top rtcc_top_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tick_32k, .cpu_active_or_sleep,
        .clk_out_pin_en, .clock_output_pin, .clock_irq_request_flag,
        .free_run_mode
    );

    task report_and_stop;
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask

    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            report_and_stop;
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // one count tick on every clock for n cycles
    task run_ticks(input int n);
        tick_32k <= 1'b1;
        repeat (n) @(posedge pclk);
        tick_32k <= 1'b0;
    endtask

    // cycles to the next low to high step of the output pin
    task rise(output int n);
        logic p;
        n = 0;
        p = 1'b1;
        repeat (200) begin
            @(negedge pclk);
            n++;
            if (p === 1'b0 && clock_output_pin === 1'b1) break;
            p = clock_output_pin;
        end
        if (n >= 200) begin
            err_total++;
            report_and_stop;
        end
    endtask

    task t_regs;
        rchk(C1, 32'h00);
        rchk(CS, 32'h08);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, serr}, 32'h1);
        wr(C1, 32'hEF);
        rchk(C1, 32'hE0);
        wr(C2, 32'hE0);
        rchk(C2, 32'h20);
        wr(CS, 32'hFF);
        rchk(CS, 32'h6F);
        @(negedge pclk);
        chk({31'h0, free_run_mode}, 32'h1);
    endtask

    task t_srst;
        wr(C1, 32'hF0);
        rchk(C1, 32'h10);
        wr(C2, 32'h02);
        rchk(C2, 32'h00);
        wr(CS, 32'h28);
        rchk(CS, 32'h28);
        @(negedge pclk);
        chk({31'h0, free_run_mode}, 32'h0);
        wr(C1, 32'h00);
        wr(C2, 32'h01);
        rchk(C2, 32'h01);
    endtask

    task t_clkout;
        int k, n;
        clk_out_pin_en <= 1'b1;
        cpu_active_or_sleep <= 1'b1;
        for (k = 0; k < 4; k++) begin
            wr(CS, {25'h0, k[1:0], 5'h08});
            rise(n);
            rise(n);
            chk(32'(n), 32'h4 << k);
        end
        @(posedge pclk);
        cpu_active_or_sleep <= 1'b0;
        repeat (3) @(posedge pclk);
        repeat (8) begin
            @(negedge pclk);
            chk({31'h0, clock_output_pin}, 32'h0);
        end
    endtask

    // hour 11 rolls to 0 one second later, afternoon flag toggles
    task t_half(input logic [31:0] en, input logic [31:0] pm);
        wr(SE, 32'd59);
        wr(MI, 32'd59);
        wr(HR, 32'd11);
        wr(C1, 32'h80 | pm);
        wr(FL, 32'h0);
        rchk(FL, 32'h0);
        wr(C2, en);
        run_ticks(32768);
        rchk(HR, 32'h0);
        rchk(SE, 32'h0);
        rchk(C1, 32'h80 | (pm ^ 32'h20));
        rchk(FL, 32'h1);
    endtask

    task t_free;
        int n;
        logic [31:0] v;
        wr(C1, 32'h00);
        wr(CS, 32'h00);
        wr(C2, 32'h20);
        wr(SE, 32'h55);
        rchk(SE, 32'h55);
        wr(SE, 32'hFE);
        wr(FL, 32'h0);
        wr(C1, 32'h80);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (clock_irq_request_flag !== 1'b1 && n < 100);
        chk({31'h0, clock_irq_request_flag}, 32'h1);
        if (clock_irq_request_flag !== 1'b1) report_and_stop;
        wr(C1, 32'h00);
        apb(1'b0, SE, 32'h0);
        v = rd;
        chk(v >> 1, 32'h0);
        repeat (40) @(posedge pclk);
        rchk(SE, v);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_srst;
        t_clkout;
        t_half(32'h04, 32'h00);
        t_half(32'h08, 32'h20);
        t_free;
        report_and_stop;
    end
endmodule
